/* fspc_pkg.sv */
package fspc_pkg;

	// ==========================================================
	// geometry
	localparam int PAGE_WORDS = 32;
	localparam int OFS_W      = 5;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 16;
	localparam int DPAIRS     = 4;

	// ==========================================================
	// register addresses (bank-0 ones answer in either bank)
	localparam logic [7:0] A_ADDR_LO  = 8'h30;
	localparam logic [7:0] A_DATA0_LO = 8'h31;
	localparam logic [7:0] A_BUF_CTL  = 8'h40;
	localparam logic [7:0] A_CONTROL  = 8'h41;
	localparam logic [7:0] A_ADDR_HI  = 8'h42;
	localparam logic [7:0] A_DATA0_HI = 8'h43;

	// ==========================================================
	// control register fields
	localparam int B_WEN_STAT = 7;
	localparam int B_MODE_LSB = 4;
	localparam int B_MODE_CHG = 3;
	localparam int B_WR_CYC   = 2;
	localparam int B_RD_EN    = 1;
	localparam int B_RD_CYC   = 0;
	localparam int B_BUF_CLR  = 0;
	localparam logic [7:0] CONTROL_RST = 8'h00;

	localparam logic [2:0] MODE_WRITE = 3'b000;
	localparam logic [2:0] MODE_ERASE = 3'b001;
	localparam logic [2:0] MODE_READ  = 3'b011;
	localparam logic [2:0] MODE_WEN   = 3'b110;

	// ==========================================================
	// unlock pattern, pairs one to three, low then high
	localparam logic [7:0] UNL_1L = 8'h00;
	localparam logic [7:0] UNL_1H = 8'h04;
	localparam logic [7:0] UNL_2L = 8'h0D;
	localparam logic [7:0] UNL_2H = 8'h09;
	localparam logic [7:0] UNL_3L = 8'hC3;
	localparam logic [7:0] UNL_3H = 8'h40;

	// ==========================================================
	// timing
	localparam int CLK_KHZ          = 100000;
	localparam int WRITE_HOLD_MS    = 2;
	localparam int UNLOCK_WIN_MS    = 1;
	localparam int WRITE_HOLD_CYC   = WRITE_HOLD_MS * CLK_KHZ;
	localparam int UNLOCK_WIN_CYC   = UNLOCK_WIN_MS * CLK_KHZ;
	localparam int CNT_W            = 20;

	// ==========================================================
	// flash array request
	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_PROG  = 2'b01,
		OP_ERASE = 2'b10
	} fspc_op_e;

	typedef struct packed {
		logic              valid;
		fspc_op_e          op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fspc_flash_req_s;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_READ   = 3'b001,
		ST_SCAN   = 3'b010,
		ST_PROG   = 3'b011,
		ST_HOLD   = 3'b100,
		ST_ERASE  = 3'b101,
		ST_UNLOCK = 3'b110
	} fspc_state_e;

endpackage

/* fspc_top.sv */
`timescale 1ns/1ps
module fspc_top #(
	parameter int WRITE_HOLD_CYC = fspc_pkg::WRITE_HOLD_CYC,
	parameter int UNLOCK_WIN_CYC = fspc_pkg::UNLOCK_WIN_CYC
) (
	input  wire logic                     clk,         // system clock
	input  wire logic                     rst_b,       // async reset, low
	input  wire logic [7:0]               sfr_addr,    // register address
	input  wire logic                     sfr_bank1,   // access made in bank 1
	input  wire logic                     sfr_wr,      // write strobe
	input  wire logic                     sfr_rd,      // read strobe
	input  wire logic [7:0]               sfr_wdata,   // write data
	output logic [7:0]                    sfr_rdata,   // read data, next cycle
	output fspc_pkg::fspc_flash_req_s     flash_req,   // array request
	input  wire logic                     flash_ack,   // array done, pulse
	input  wire logic [15:0]              flash_rdata  // array read word
);

	// ==========================================================
	// state
	fspc_pkg::fspc_state_e         state_q;
	logic [2:0]                    mode_q;
	logic                          rden_q;
	logic                          frd_q;
	logic                          fwt_q;
	logic                          bwt_q;
	logic                          flash_write_enable_flag_q;
	logic                          buffer_clear_request_q;
	logic [fspc_pkg::OFS_W-1:0]    idx_q;
	logic [fspc_pkg::CNT_W-1:0]    cnt_q;
	logic [fspc_pkg::ADDR_W-1:0]   addr_q;
	logic [7:0]                    dlo_q [fspc_pkg::DPAIRS];
	logic [7:0]                    dhi_q [fspc_pkg::DPAIRS];
	logic [15:0]                   buf_q [fspc_pkg::PAGE_WORDS];
	logic [fspc_pkg::PAGE_WORDS-1:0] bvalid_q;
	logic [7:0]                    rdata_q;
	fspc_pkg::fspc_flash_req_s     req_q;

	// ==========================================================
	// decode
	logic       idle;
	logic       wr_alo;
	logic       wr_ahi;
	logic       wr_ctl;
	logic       wr_bctl;
	logic       rd_done;
	logic       hold_done;
	logic       load_ok;
	logic       pattern_ok;
	logic [3:0] wr_dlo;
	logic [3:0] wr_dhi;
	logic [2:0] wmode;

	assign idle      = (state_q == fspc_pkg::ST_IDLE);
	assign wmode     = sfr_wdata[fspc_pkg::B_MODE_LSB +: 3];
	assign wr_alo    = sfr_wr && (sfr_addr == fspc_pkg::A_ADDR_LO);
	// bank-1 registers only answer when sfr_bank1 is set
	assign wr_ahi    = sfr_wr && sfr_bank1 && (sfr_addr == fspc_pkg::A_ADDR_HI);
	assign wr_ctl    = sfr_wr && sfr_bank1 && (sfr_addr == fspc_pkg::A_CONTROL);
	assign wr_bctl   = sfr_wr && sfr_bank1 && (sfr_addr == fspc_pkg::A_BUF_CTL);
	assign rd_done   = (state_q == fspc_pkg::ST_READ) && flash_ack;
	assign hold_done = (state_q == fspc_pkg::ST_HOLD)
	                   && (cnt_q == fspc_pkg::CNT_W'(WRITE_HOLD_CYC - 1));

	genvar gi;
	generate
		for (gi = 0; gi < fspc_pkg::DPAIRS; gi++) begin : g_dec
			assign wr_dlo[gi] = sfr_wr && (sfr_addr == fspc_pkg::A_DATA0_LO + 8'(gi));
			assign wr_dhi[gi] = sfr_wr && sfr_bank1
			                    && (sfr_addr == fspc_pkg::A_DATA0_HI + 8'(gi));
		end
	endgenerate

	assign load_ok = wr_dhi[0] && flash_write_enable_flag_q && idle
	                 && (addr_q[fspc_pkg::OFS_W-1:0] != 5'h1F);

	assign pattern_ok = (dlo_q[1] == fspc_pkg::UNL_1L) && (dhi_q[1] == fspc_pkg::UNL_1H)
	                 && (dlo_q[2] == fspc_pkg::UNL_2L) && (dhi_q[2] == fspc_pkg::UNL_2H)
	                 && (dlo_q[3] == fspc_pkg::UNL_3L) && (dhi_q[3] == fspc_pkg::UNL_3H);

	// ==========================================================
	// address and data registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q <= 12'h000;
			for (int i = 0; i < fspc_pkg::DPAIRS; i++) begin
				dlo_q[i] <= 8'h00;
				dhi_q[i] <= 8'h00;
			end
		end else begin
			if (wr_alo)
				addr_q[7:0] <= sfr_wdata;
			if (wr_ahi)
				addr_q[11:8] <= sfr_wdata[3:0];
			for (int i = 0; i < fspc_pkg::DPAIRS; i++) begin
				if (wr_dlo[i])
					dlo_q[i] <= sfr_wdata;
				if (wr_dhi[i])
					dhi_q[i] <= sfr_wdata;
			end
			if (load_ok)
				addr_q <= addr_q + 12'h001;
			if (rd_done) begin
				dlo_q[0] <= flash_rdata[7:0];
				dhi_q[0] <= flash_rdata[15:8];
			end
		end
	end

	// ==========================================================
	// write buffer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buffer_clear_request_q <= 1'b0;
		end else if (wr_bctl) begin
			// a software set in the clearing cycle wins over the self-clear
			buffer_clear_request_q <= sfr_wdata[fspc_pkg::B_BUF_CLR];
		end else if (buffer_clear_request_q) begin
			buffer_clear_request_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_q <= 32'h0000_0000;
		end else begin
			if (buffer_clear_request_q || hold_done)
				bvalid_q <= 32'h0000_0000;
			if (load_ok)
				bvalid_q[addr_q[fspc_pkg::OFS_W-1:0]] <= 1'b1;
		end
	end

	// data words carry no reset: the valid bits decide what is programmed
	always_ff @(posedge clk) begin
		// word from low and high pair
		if (load_ok)
			buf_q[addr_q[fspc_pkg::OFS_W-1:0]] <= {sfr_wdata, dlo_q[0]};
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= fspc_pkg::ST_IDLE;
			mode_q  <= 3'b000;
			rden_q  <= 1'b0;
			frd_q   <= 1'b0;
			fwt_q   <= 1'b0;
			bwt_q   <= 1'b0;
			flash_write_enable_flag_q  <= 1'b0;
			idx_q   <= 5'h00;
			cnt_q   <= 20'h0_0000;
			req_q   <= '0;
		end else begin
			if (wr_ctl && !sfr_wdata[fspc_pkg::B_WEN_STAT])
				flash_write_enable_flag_q <= 1'b0;
			if (wr_ctl)
				rden_q <= sfr_wdata[fspc_pkg::B_RD_EN];
			unique case (state_q)
				fspc_pkg::ST_IDLE: begin
					// non-enable mode change finishes on the next cycle
					if (bwt_q)
						bwt_q <= 1'b0;
					if (wr_ctl) begin
						mode_q <= wmode;
						if (sfr_wdata[fspc_pkg::B_RD_CYC] && rden_q) begin
							frd_q   <= 1'b1;
							state_q <= fspc_pkg::ST_READ;
							req_q   <= '{valid: 1'b1, op: fspc_pkg::OP_READ,
							             addr: addr_q, wdata: 16'h0000};
						end else if (sfr_wdata[fspc_pkg::B_WR_CYC] && flash_write_enable_flag_q
						             && wmode == fspc_pkg::MODE_WRITE) begin
							fwt_q   <= 1'b1;
							idx_q   <= 5'h00;
							state_q <= fspc_pkg::ST_SCAN;
						end else if (sfr_wdata[fspc_pkg::B_WR_CYC] && flash_write_enable_flag_q
						             && wmode == fspc_pkg::MODE_ERASE) begin
							fwt_q   <= 1'b1;
							state_q <= fspc_pkg::ST_ERASE;
							req_q   <= '{valid: 1'b1, op: fspc_pkg::OP_ERASE,
							             addr: {addr_q[11:5], 5'h00}, wdata: 16'h0000};
						end else if (sfr_wdata[fspc_pkg::B_MODE_CHG]) begin
							bwt_q <= 1'b1;
							cnt_q <= 20'h0_0000;
							if (wmode == fspc_pkg::MODE_WEN)
								state_q <= fspc_pkg::ST_UNLOCK;
						end
					end
				end
				fspc_pkg::ST_READ: begin
					if (flash_ack) begin
						req_q.valid <= 1'b0;
						frd_q       <= 1'b0;
						state_q     <= fspc_pkg::ST_IDLE;
					end
				end
				fspc_pkg::ST_SCAN: begin
					if (bvalid_q[idx_q]) begin
						req_q   <= '{valid: 1'b1, op: fspc_pkg::OP_PROG,
						             addr: {addr_q[11:5], idx_q}, wdata: buf_q[idx_q]};
						state_q <= fspc_pkg::ST_PROG;
					end else if (idx_q == 5'h1F) begin
						cnt_q   <= 20'h0_0000;
						state_q <= fspc_pkg::ST_HOLD;
					end else begin
						idx_q <= idx_q + 5'h01;
					end
				end
				fspc_pkg::ST_PROG: begin
					if (flash_ack) begin
						req_q.valid <= 1'b0;
						if (idx_q == 5'h1F) begin
							cnt_q   <= 20'h0_0000;
							state_q <= fspc_pkg::ST_HOLD;
						end else begin
							idx_q   <= idx_q + 5'h01;
							state_q <= fspc_pkg::ST_SCAN;
						end
					end
				end
				fspc_pkg::ST_HOLD: begin
					if (hold_done) begin
						fwt_q   <= 1'b0;
						state_q <= fspc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 20'h0_0001;
					end
				end
				fspc_pkg::ST_ERASE: begin
					if (flash_ack) begin
						req_q.valid <= 1'b0;
						fwt_q       <= 1'b0;
						state_q     <= fspc_pkg::ST_IDLE;
					end
				end
				fspc_pkg::ST_UNLOCK: begin
					if (pattern_ok) begin
						flash_write_enable_flag_q  <= 1'b1;
						bwt_q   <= 1'b0;
						state_q <= fspc_pkg::ST_IDLE;
					end else if (cnt_q == fspc_pkg::CNT_W'(UNLOCK_WIN_CYC - 1)) begin
						bwt_q   <= 1'b0;
						state_q <= fspc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 20'h0_0001;
					end
				end
				default: begin
					state_q <= fspc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// register read port
	logic [7:0] rmux;

	always_comb begin
		rmux = 8'h00;
		if (sfr_addr == fspc_pkg::A_ADDR_LO)
			rmux = addr_q[7:0];
		for (int i = 0; i < fspc_pkg::DPAIRS; i++) begin
			if (sfr_addr == fspc_pkg::A_DATA0_LO + 8'(i))
				rmux = dlo_q[i];
			if (sfr_bank1 && sfr_addr == fspc_pkg::A_DATA0_HI + 8'(i))
				rmux = dhi_q[i];
		end
		if (sfr_bank1) begin
			unique case (sfr_addr)
				fspc_pkg::A_ADDR_HI: rmux = {4'h0, addr_q[11:8]};
				fspc_pkg::A_CONTROL: rmux = {flash_write_enable_flag_q, mode_q, bwt_q, fwt_q, rden_q, frd_q};
				fspc_pkg::A_BUF_CTL: rmux = {7'h00, buffer_clear_request_q};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rdata_q <= 8'h00;
		else if (sfr_rd)
			rdata_q <= rmux;
	end

	assign sfr_rdata = rdata_q;
	assign flash_req = req_q;

endmodule // fspc_top

/* fspc_flash_mdl.sv */
`timescale 1ns/1ps
// ==========================================================
// flash array model
module fspc_flash_mdl (
	input  wire logic                 clk,   // system clock
	input  wire logic                 slow,  // long answer delay
	input  fspc_pkg::fspc_flash_req_s req,   // request from block
	output logic                      ack,   // one-cycle done
	output logic [15:0]               rdata  // read word
);
	logic [15:0] mem [4096];
	logic [3:0]  cnt_q;
	initial begin
		ack = 1'b0;
		rdata = 16'h0000;
		cnt_q = 4'h0;
		foreach (mem[i]) mem[i] = 16'hFFFF;
	end
	always @(posedge clk) begin
		ack <= 1'b0;
		// released read bus keeps toggling
		rdata <= ~rdata;
		if (req.valid && !ack) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == (slow ? 4'h7 : 4'h1)) begin
				cnt_q <= 4'h0;
				ack <= 1'b1;
				if (req.op == fspc_pkg::OP_READ) rdata <= mem[req.addr];
				if (req.op == fspc_pkg::OP_ERASE)
					for (int i = 0; i < 32; i++) mem[{req.addr[11:5], 5'(i)}] <= 16'hFFFF;
				// programming only clears bits of the addressed word
				if (req.op == fspc_pkg::OP_PROG) mem[req.addr] <= mem[req.addr] & req.wdata;
			end
		end
	end
endmodule // fspc_flash_mdl

/* fspc_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker
module fspc_chk #(
	parameter int WRITE_HOLD_CYC = 20,
	parameter int UNLOCK_WIN_CYC = 30
) (
	input wire logic                 clk,         // system clock
	input wire logic                 rst_b,       // async reset, low
	input wire logic [7:0]           sfr_addr,    // register address
	input wire logic                 sfr_bank1,   // bank 1 access
	input wire logic                 sfr_wr,      // write strobe
	input wire logic                 sfr_rd,      // read strobe
	input wire logic [7:0]           sfr_wdata,   // write data
	input wire logic [7:0]           sfr_rdata,   // read data
	input fspc_pkg::fspc_flash_req_s flash_req,   // array request
	input wire logic                 flash_ack,   // array done
	input wire logic [15:0]          flash_rdata  // array word
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic ctl_wr;
	logic rd_ack;
	logic er_wr;
	assign ctl_wr = sfr_wr && sfr_bank1 && sfr_addr == fspc_pkg::A_CONTROL;
	assign er_wr = ctl_wr && sfr_wdata[6:4] == fspc_pkg::MODE_ERASE && sfr_wdata[2];
	assign rd_ack = flash_req.valid && flash_req.op == fspc_pkg::OP_READ && flash_ack;
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	AST_HI_NIBBLE: assert property (sfr_rd && sfr_bank1 && sfr_addr == 8'h42 |=>
		sfr_rdata[7:4] == 4'h0) else $error("address high upper nibble not zero");
	AST_BANK1_ONLY: assert property (sfr_rd && !sfr_bank1 && sfr_addr inside {[8'h40:8'h46]}
		|=> sfr_rdata == 8'h00) else $error("bank one register read without bank");
	AST_READ_CAUSE: assert property ($rose(flash_req.valid) && flash_req.op == fspc_pkg::OP_READ
		|-> $past(ctl_wr && sfr_wdata[0]) || $past(ctl_wr && sfr_wdata[0], 2))
		else $error("read request without read start");
	AST_ERASE_CAUSE: assert property ($rose(flash_req.valid) && flash_req.op == fspc_pkg::OP_ERASE
		|-> $past(er_wr) || $past(er_wr, 2)) else $error("erase without erase mode");
	AST_ERASE_PAGE: assert property (flash_req.valid && flash_req.op == fspc_pkg::OP_ERASE
		|-> flash_req.addr[4:0] == 5'h00) else $error("erase address not page aligned");
	AST_REQ_HOLD: assert property (flash_req.valid && !flash_ack |=> $stable(flash_req))
		else $error("request changed before answer");
	AST_REQ_DONE: assert property (flash_req.valid && flash_ack && flash_req.op !=
		fspc_pkg::OP_PROG |=> !flash_req.valid) else $error("request kept after answer");
	AST_READ_WORD: assert property (rd_ack ##1 (sfr_rd && sfr_addr == 8'h31) |=>
		sfr_rdata == $past(flash_rdata[7:0], 2)) else $error("read word not in data0 low");
	COV_READ: cover property (rd_ack);
	COV_PROG: cover property (flash_req.valid && flash_req.op == fspc_pkg::OP_PROG && flash_ack);
	COV_ERASE: cover property (flash_req.valid && flash_req.op == fspc_pkg::OP_ERASE && flash_ack);
endmodule // fspc_chk
bind fspc_top fspc_chk #(.WRITE_HOLD_CYC(WRITE_HOLD_CYC), .UNLOCK_WIN_CYC(UNLOCK_WIN_CYC)) i_chk (
	.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_bank1(sfr_bank1), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_req(flash_req),
	.flash_ack(flash_ack), .flash_rdata(flash_rdata));

/* fspc_top_tb.sv */
`timescale 1ns/1ps
module fspc_top_tb;
	typedef logic [24:0] fspc_row_t;
	logic                      clk = 1'b0;
	logic                      rst_b = 1'b0;
	logic [7:0]                sfr_addr = 8'h00;
	logic                      sfr_bank1 = 1'b0;
	logic                      sfr_wr = 1'b0;
	logic                      sfr_rd = 1'b0;
	logic [7:0]                sfr_wdata = 8'h00;
	logic [7:0]                sfr_rdata;
	fspc_pkg::fspc_flash_req_s flash_req;
	logic                      flash_ack;
	logic [15:0]               flash_rdata;
	logic                      slow = 1'b0;
	int                        n_errors = 0;
	int                        n_compared = 0;
	int                        cyc = 0;
	logic [7:0]                v;
	logic [15:0]               w;
	// rows: address, bank, written, expected back
	fspc_row_t rows [6] = '{{8'h30, 1'b0, 8'hA5, 8'hA5}, {8'h42, 1'b1, 8'hFF, 8'h0F},
		{8'h33, 1'b0, 8'h3C, 8'h3C}, {8'h46, 1'b1, 8'h7E, 8'h7E}, {8'h42, 1'b0, 8'h55, 8'h00},
		{8'h50, 1'b0, 8'h77, 8'h00}};
	always #5 clk = ~clk;
	fspc_top #(.WRITE_HOLD_CYC(20), .UNLOCK_WIN_CYC(30)) i_dut (.clk(clk), .rst_b(rst_b),
		.sfr_addr(sfr_addr), .sfr_bank1(sfr_bank1), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_req(flash_req),
		.flash_ack(flash_ack), .flash_rdata(flash_rdata));
	fspc_flash_mdl i_mdl (.clk(clk), .slow(slow), .req(flash_req), .ack(flash_ack),
		.rdata(flash_rdata));
	task automatic tally_and_finish();
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// bank-one registers go through the bank flag
	task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_bank1 = b;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_bank1 = b;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic poll(input logic [7:0] m);
		v = m;
		for (int i = 0; i < 100 && (v & m) != 8'h00; i++) rd(8'h41, 1'b1, v);
		check(v & m, 8'h00);
	endtask
	task automatic set_addr(input logic [11:0] a);
		wr(8'h30, 1'b0, a[7:0]);
		wr(8'h42, 1'b1, {4'h0, a[11:8]});
	endtask
	task automatic load(input logic [15:0] d);
		wr(8'h31, 1'b0, d[7:0]);
		wr(8'h43, 1'b1, d[15:8]);
	endtask
	// enable and start go in separate writes, bit 7 kept high
	task automatic read_word(input logic [11:0] a, output logic [15:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		set_addr(a);
		wr(8'h41, 1'b1, 8'h82);
		wr(8'h41, 1'b1, 8'h83);
		for (int i = 0; i < 50 && flash_ack !== 1'b1; i++) @(negedge clk);
		rd(8'h31, 1'b0, lo);
		rd(8'h43, 1'b1, hi);
		d = {hi, lo};
		rd(8'h41, 1'b1, v);
		check(v[0], 1'b0);
	endtask
	// pattern into pairs one to three, last byte varied
	task automatic unlock(input logic [7:0] last);
		wr(8'h32, 1'b0, fspc_pkg::UNL_1L);
		wr(8'h44, 1'b1, fspc_pkg::UNL_1H);
		wr(8'h33, 1'b0, fspc_pkg::UNL_2L);
		wr(8'h45, 1'b1, fspc_pkg::UNL_2H);
		wr(8'h34, 1'b0, fspc_pkg::UNL_3L);
		wr(8'h46, 1'b1, last);
		wr(8'h41, 1'b1, 8'h68);
		poll(8'h08);
		rd(8'h41, 1'b1, v);
	endtask
	task automatic prog_page();
		wr(8'h41, 1'b1, 8'h84);
		poll(8'h04);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		rd(8'h41, 1'b1, v);
		check(v, fspc_pkg::CONTROL_RST);
		rd(8'h40, 1'b1, v);
		check(v, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][24:17], rows[i][16], rows[i][15:8]);
			rd(rows[i][24:17], rows[i][16], v);
			check(v, rows[i][7:0]);
		end
		// bit 7 set and read start with enable not yet on
		wr(8'h41, 1'b1, 8'h80);
		wr(8'h41, 1'b1, 8'h03);
		repeat (4) @(negedge clk);
		check(flash_req.valid, 1'b0);
		rd(8'h41, 1'b1, v);
		check(v[7], 1'b0);
		set_addr(12'h13E);
		load(16'h1111);
		rd(8'h30, 1'b0, v);
		check(v, 8'h3E);
		unlock(8'h41);
		check(v[7], 1'b0);
		unlock(fspc_pkg::UNL_3H);
		check(v[7], 1'b1);
		load(16'hBEEF);
		rd(8'h30, 1'b0, v);
		check(v, 8'h3F);
		load(16'h1234);
		rd(8'h30, 1'b0, v);
		check(v, 8'h3F);
		set_addr(12'h125);
		load(16'h0F0F);
		slow = 1'b1;
		prog_page();
		read_word(12'h13E, w);
		check(w, 16'hBEEF);
		read_word(12'h13F, w);
		check(w, 16'hFFFF);
		read_word(12'h125, w);
		check(w, 16'h0F0F);
		read_word(12'h120, w);
		check(w, 16'hFFFF);
		wr(8'h41, 1'b1, 8'h94);
		poll(8'h04);
		read_word(12'h125, w);
		check(w, 16'hFFFF);
		// empty program after erase shows the buffer was emptied
		prog_page();
		read_word(12'h13E, w);
		check(w, 16'hFFFF);
		set_addr(12'h12A);
		load(16'h0000);
		wr(8'h40, 1'b1, 8'h01);
		rd(8'h40, 1'b1, v);
		check(v, 8'h00);
		prog_page();
		read_word(12'h12A, w);
		check(w, 16'hFFFF);
		// reserved mode with write start starts no write cycle
		wr(8'h41, 1'b1, 8'hA4);
		rd(8'h41, 1'b1, v);
		check(v[2], 1'b0);
		wr(8'h41, 1'b1, 8'h00);
		rd(8'h41, 1'b1, v);
		check(v[7], 1'b0);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		rd(8'h30, 1'b0, v);
		check(v, 8'h00);
		tally_and_finish();
	end
endmodule // fspc_top_tb
